// ### dac_link_defines.svh
// Constants shared by both ends of the two-wire DAC link.
// Assumes a 125 MHz system clock on both ends.
`ifndef DAC_LINK_DEFINES_SVH
`define DAC_LINK_DEFINES_SVH
`define DEV_ADDR 7'h48
`define CMD_DAC_CODE 8'h00
`define CMD_SETUP 8'h01
`define DAC_CODE_RESET 8'h00
`define SETUP_RESET 8'h00
`define STANDBY_BIT 0
`define SYS_CLK_MHZ 125
`define SCL_HALF_NS 5000
`define SCL_HALF_CYC ((`SCL_HALF_NS * `SYS_CLK_MHZ + 999) / 1000)
`define HOST_REG_CTRL 4'h0
`define HOST_REG_WDATA 4'h4
`define HOST_REG_STATUS 4'h8
`endif

// ### dac_link_device.sv
// Device end of the two-wire DAC port: a slave holding the DAC code and setup registers.
// Assumes an open-drain bus carried by dac_link_if and a 125 MHz aclk.
//
// Behaviour
// - Answer only to address 1001000.
// - Stay silent until a START is seen.
// - STOP ends the access, back to waiting.
// - Master closes every access with STOP.
// - Master sends address byte right after START.
// - All bytes travel most significant bit first.
// - Matching address is acknowledged by pulling low.
// - Eighth address bit: 1 read, 0 write.
// - First phase writes the command byte.
// - Receiver pulls data low on ninth pulse.
// - Acknowledge data byte after it is stored.
// - Idle bus leaves both lines high.
// - Device is slave only; master clocks everything.
// - Byte write: address, command, data, STOP.
// - Byte read uses repeated START, master NACKs.
// - Command 00h data, 01h setup register.
// - Both registers are eight bits wide; setup keeps only the standby bit, its other seven bits read zero.
// - Standby bit halts conversion.
// - Serial port keeps working in standby.
`timescale 1ns/10ps
`include "dac_link_defines.svh"
module dac_link_device
    import dac_link_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Two-wire bus.
    dac_link_if.device link,
    // User side: register contents and converter state.
    output logic [7:0] dac_code,
    output logic [7:0] setup_register,
    output logic converting
);
    // Three-stage samplers of both lines.
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    // Debounced line levels, updated when stages two and three agree.
    logic scl_q;
    logic sda_q;
    // Receiver state and byte shifter.
    dev_state_t state_q;
    dev_state_t after_ack_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] cmd_q;
    logic read_q;
    logic sda_oe_q;
    logic [7:0] dac_code_q;
    logic [7:0] setup_q;
    logic converting_q;

    // Line events taken from the filtered levels.
    wire scl_new = (scl_s_q[2] == scl_s_q[1]) ? scl_s_q[2] : scl_q;
    wire sda_new = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[2] : sda_q;
    wire scl_rise = scl_new & ~scl_q;
    wire scl_fall = ~scl_new & scl_q;
    wire start_seen = scl_q & scl_new & sda_q & ~sda_new;
    wire stop_seen = scl_q & scl_new & ~sda_q & sda_new;
    wire [7:0] shift_in = {shift_q[6:0], sda_new};
    // Register selected by the command; unknown codes read as zero.
    wire [7:0] read_value = (cmd_q == `CMD_DAC_CODE) ? dac_code_q :
                            (cmd_q == `CMD_SETUP) ? setup_q : 8'h00;
    wire byte_done = scl_rise & (bit_cnt_q == 4'h7);

    // Sample both lines through three flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], link.scl};
            sda_s_q <= {sda_s_q[1:0], link.sda};
            scl_q <= scl_new;
            sda_q <= sda_new;
        end
    end

    // Serial receiver and register writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= dev_idle;
            after_ack_q <= dev_idle;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            cmd_q <= 8'h00;
            read_q <= 1'b0;
            sda_oe_q <= 1'b0;
            dac_code_q <= `DAC_CODE_RESET;
            setup_q <= `SETUP_RESET;
        end else if (start_seen) begin
            // A START, first or repeated, always begins a new address byte.
            state_q <= dev_addr;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_seen) begin
            state_q <= dev_idle;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                dev_idle: begin
                    // Released line, waiting for START; also taken on a mismatch.
                    sda_oe_q <= 1'b0;
                end
                dev_addr, dev_cmd, dev_wdata: begin
                    // Bits are taken on the rising clock, first bit is the MSB.
                    if (scl_rise) begin
                        shift_q <= shift_in;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == dev_addr) begin
                            if (shift_in[7:1] == `DEV_ADDR) begin
                                read_q <= shift_in[0];
                                after_ack_q <= shift_in[0] ? dev_rdata : dev_cmd;
                                state_q <= dev_ack;
                            end else begin
                                state_q <= dev_idle;
                            end
                        end else if (state_q == dev_cmd) begin
                            cmd_q <= shift_in;
                            after_ack_q <= dev_wdata;
                            state_q <= dev_ack;
                        end else begin
                            // Store first, then acknowledge on the ninth pulse.
                            if (cmd_q == `CMD_DAC_CODE) begin
                                dac_code_q <= shift_in;
                            end else if (cmd_q == `CMD_SETUP) begin
                                setup_q <= {7'h00, shift_in[`STANDBY_BIT]};
                            end
                            after_ack_q <= dev_wdata;
                            state_q <= dev_ack;
                        end
                    end
                end
                dev_ack: begin
                    // Pull low after the eighth falling edge; after the ninth, release or put out the first read bit.
                    if (scl_fall) begin
                        if (!sda_oe_q) begin
                            sda_oe_q <= 1'b1;
                        end else begin
                            state_q <= after_ack_q;
                            shift_q <= read_value;
                            sda_oe_q <= (after_ack_q == dev_rdata) & ~read_value[7];
                            bit_cnt_q <= 4'h0;
                        end
                    end
                end
                dev_rdata: begin
                    // Shift the selected register out, MSB first, on falling clock.
                    if (scl_fall) begin
                        if (bit_cnt_q == 4'h7) begin
                            sda_oe_q <= 1'b0;
                            state_q <= dev_mack;
                        end else begin
                            sda_oe_q <= ~shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                dev_mack: begin
                    // Master's acknowledge slot; a NACK is expected, then STOP.
                    if (scl_fall) begin
                        state_q <= dev_idle;
                    end
                end
                default: begin
                    state_q <= dev_idle;
                end
            endcase
        end
    end

    // Converter runs unless standby is set; the port is unaffected.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converting_q <= 1'b0;
        end else begin
            converting_q <= ~setup_q[`STANDBY_BIT];
        end
    end

    assign link.sda_oe_dev = sda_oe_q;
    assign dac_code = dac_code_q;
    assign setup_register = setup_q;
    assign converting = converting_q;
endmodule // dac_link_device

// ### dac_link_host.sv
// Host end of the two-wire DAC port: an AXI4-Lite slave that runs byte writes and byte reads.
// Assumes an open-drain bus carried by dac_link_if and a 125 MHz aclk.
`timescale 1ns/10ps
`include "dac_link_defines.svh"
module dac_link_host
    import dac_link_pkg::*;
#(
    parameter int HALF_CYC = `SCL_HALF_CYC
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Two-wire bus.
    dac_link_if.host link
);
    initial begin
        if (HALF_CYC < 4 || HALF_CYC > 65535) begin
            $error("HALF_CYC out of range");
        end
    end

    // Sequencer and its data.
    hst_state_t state_q;
    logic [15:0] tmr_q;
    logic [1:0] phase_q;
    logic [35:0] frame_q;
    logic [5:0] idx_q;
    logic [5:0] last_q;
    logic [5:0] rs_q;
    logic do_read_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic [7:0] cmd_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic nack_q;
    logic [2:0] sda_s_q;
    // AXI side registers.
    logic aw_q;
    logic w_q;
    logic [3:0] awaddr_q;
    logic [31:0] wd_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_out_q;

    wire busy = (state_q != hst_idle);
    wire tick = (tmr_q == 16'h0000);
    wire sda_in = sda_s_q[2];
    wire wr_go = aw_q & w_q & ~bvalid_q;
    wire go_now = wr_go & ~busy & (awaddr_q == `HOST_REG_CTRL);
    wire [7:0] ctrl_cmd = wd_q[7:0];
    wire ctrl_read = wd_q[8];
    wire [31:0] status_word = {14'h0000, nack_q, busy, 8'h00, rdata_q};
    wire [31:0] rd_mux = (s_axi_araddr == `HOST_REG_STATUS) ? status_word :
                         (s_axi_araddr == `HOST_REG_WDATA) ? {24'h000000, wdata_q} :
                         {24'h000000, cmd_q};
    // Bit sent in each ninth slot is a release; read byte bits are released too.
    wire [35:0] wr_frame = {`DEV_ADDR, 1'b0, 1'b1, ctrl_cmd, 1'b1, wdata_q, 1'b1, 9'h1ff};
    wire [35:0] rd_frame = {`DEV_ADDR, 1'b0, 1'b1, ctrl_cmd, 1'b1, `DEV_ADDR, 1'b1, 1'b1, 8'hff, 1'b1};
    wire bit_is_ack = (idx_q == 6'd8) | (idx_q == 6'd17) | (idx_q == 6'd26);

    // Bus input sampler.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_s_q <= 3'h7;
        end else begin
            sda_s_q <= {sda_s_q[1:0], link.sda};
        end
    end

    // AXI4-Lite slave: capture address and data in either order, answer one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wd_q <= 32'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_out_q <= 32'h0;
            cmd_q <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            awready_q <= ~aw_q & ~awready_q & s_axi_awvalid;
            wready_q <= ~w_q & ~wready_q & s_axi_wvalid;
            if (awready_q & s_axi_awvalid) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (wready_q & s_axi_wvalid) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (wr_go) begin
                // Writes to the control word while busy are dropped.
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (awaddr_q == `HOST_REG_CTRL && !busy) begin
                    cmd_q <= ctrl_cmd;
                end else if (awaddr_q == `HOST_REG_WDATA) begin
                    wdata_q <= wd_q[7:0];
                end
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            arready_q <= ~arready_q & ~rvalid_q & s_axi_arvalid;
            if (arready_q & s_axi_arvalid) begin
                rvalid_q <= 1'b1;
                rdata_out_q <= rd_mux;
            end else if (rvalid_q & s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Bit sequencer: four quarter phases per bit, data set, clock high, sample, clock low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= hst_idle;
            tmr_q <= 16'h0000;
            phase_q <= 2'h0;
            frame_q <= 36'h0;
            idx_q <= 6'd0;
            last_q <= 6'd0;
            rs_q <= 6'd0;
            do_read_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rdata_q <= 8'h00;
            nack_q <= 1'b0;
        end else begin
            tmr_q <= tick ? 16'(HALF_CYC - 1) : tmr_q - 16'h0001;
            case (state_q)
                hst_idle: begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    if (go_now) begin
                        do_read_q <= ctrl_read;
                        frame_q <= ctrl_read ? rd_frame : wr_frame;
                        last_q <= ctrl_read ? 6'd35 : 6'd26;
                        rs_q <= ctrl_read ? 6'd18 : 6'd63;
                        idx_q <= 6'd0;
                        nack_q <= 1'b0;
                        phase_q <= 2'h0;
                        state_q <= hst_start;
                    end
                end
                hst_start, hst_rstart: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: begin
                                sda_oe_q <= 1'b0;
                            end
                            2'h1: begin
                                scl_oe_q <= 1'b0;
                            end
                            2'h2: begin
                                sda_oe_q <= 1'b1;
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                state_q <= hst_bit;
                            end
                        endcase
                    end
                end
                hst_bit: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: begin
                                sda_oe_q <= ~frame_q[6'd35 - idx_q];
                            end
                            2'h1: begin
                                scl_oe_q <= 1'b0;
                            end
                            2'h2: begin
                                if (bit_is_ack && sda_in) begin
                                    nack_q <= 1'b1;
                                end
                                if (idx_q >= 6'd27 && idx_q <= 6'd34) begin
                                    rdata_q <= {rdata_q[6:0], sda_in};
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                idx_q <= idx_q + 6'd1;
                                if (idx_q == last_q || (bit_is_ack && sda_in)) begin
                                    state_q <= hst_stop;
                                end else if (idx_q + 6'd1 == rs_q) begin
                                    state_q <= hst_rstart;
                                end
                            end
                        endcase
                    end
                end
                hst_stop: begin
                    if (tick) begin
                        phase_q <= phase_q + 2'h1;
                        case (phase_q)
                            2'h0: begin
                                sda_oe_q <= 1'b1;
                            end
                            2'h1: begin
                                scl_oe_q <= 1'b0;
                            end
                            2'h2: begin
                                sda_oe_q <= 1'b0;
                            end
                            default: begin
                                state_q <= hst_idle;
                            end
                        endcase
                    end
                end
                default: begin
                    state_q <= hst_idle;
                end
            endcase
        end
    end

    assign link.scl_oe_host = scl_oe_q;
    assign link.sda_oe_host = sda_oe_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bresp = 2'b00;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rdata = rdata_out_q;
    assign s_axi_rresp = 2'b00;
    assign s_axi_rvalid = rvalid_q;
endmodule // dac_link_host

// ### dac_link_if.sv
// Open-drain two-wire bus joining the host end and the device end.
// Assumes pull-ups: a line is low whenever any party enables its driver.
`timescale 1ns/10ps
interface dac_link_if;
    // Host drives of both lines.
    logic scl_oe_host;
    logic sda_oe_host;
    // Device drive of the data line.
    logic sda_oe_dev;
    // Resolved wired-AND levels.
    wire scl = ~scl_oe_host;
    wire sda = ~(sda_oe_host | sda_oe_dev);
    // The device end: senses both lines, may pull the data line.
    modport device (input scl, input sda, output sda_oe_dev);
    // The host end: makes the clock, drives and senses data.
    modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

// ### dac_link_monitor.sv
// Checker of the two-wire link between host and device ends.
// Assumes it sits beside the interface and sees its lines.
`timescale 1ns/10ps
`include "dac_link_defines.svh"
module dac_link_monitor #(
    parameter int HALF_CYC = 8
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus lines and their drives.
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_host,
    input wire logic sda_oe_host,
    input wire logic sda_oe_dev
);
    // Longest wait from START to first clock low.
    localparam int START_MAX = 4 * HALF_CYC;
    logic scl_q, sda_q, busy_q, first_q, rd_q; // Line history and access state.
    logic [3:0] cnt_q; // Clock rises in the byte.
    logic [7:0] sh_q; // Byte bits, first at the top.
    wire start_w = scl & scl_q & sda_q & ~sda;
    wire stop_w = scl & scl_q & ~sda_q & sda;
    wire rise_w = scl & ~scl_q;
    wire ninth_w = rise_w & (cnt_q == 4'h8);
    wire match_w = (sh_q[7:1] == `DEV_ADDR);
    // Line history, the START-to-STOP span and the address-byte flag.
    always_ff @(posedge aclk) begin
        scl_q <= scl;
        sda_q <= sda;
        busy_q <= aresetn & (start_w | (busy_q & ~stop_w));
        first_q <= aresetn & ~stop_w & (start_w | (first_q & ~ninth_w));
    end
    // Count rises per byte, shift the byte in, keep the direction.
    always_ff @(posedge aclk) begin
        if (!aresetn || start_w || ninth_w) begin
            cnt_q <= 4'h0;
        end else if (rise_w) begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (rise_w && !ninth_w) begin
            sh_q <= {sh_q[6:0], sda};
        end
        if (ninth_w && first_q) begin
            rd_q <= sh_q[0];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A START on the bus.
    sequence start_s;
        start_w;
    endsequence
    dev_quiet_idle_a: assert property (!busy_q |-> !sda_oe_dev) else $error("device drives outside access");
    dev_edge_low_a: assert property ($changed(sda_oe_dev) |-> !scl) else $error("device moves data in clock high");
    addr_ack_a: assert property (ninth_w && first_q && match_w |-> !sda) else $error("address not acknowledged");
    addr_msb_first_a: assert property (ninth_w && first_q |-> match_w) else $error("address byte wrong");
    ninth_release_a: assert property (ninth_w |-> !sda_oe_host) else $error("host holds data on ninth pulse");
    host_data_stable_a: assert property (scl && $past(scl) && $changed(sda_oe_host) |-> start_w || stop_w)
        else $error("host moves data in clock high");
    stop_idle_a: assert property (stop_w |=> (scl && sda) [*4]) else $error("bus not idle after stop");
    start_clock_a: assert property (start_s |-> ##[1:START_MAX] !scl) else $error("no address after start");
    byte_ack_a: assert property (ninth_w && !first_q && !rd_q |-> !sda) else $error("byte not acknowledged");
    read_nack_a: assert property (ninth_w && !first_q && rd_q |-> sda) else $error("read not closed by nack");
endmodule // dac_link_monitor

// ### dac_link_pkg.sv
// Types shared by both ends of the two-wire DAC link.
// Assumes nothing beyond a SystemVerilog compiler.
package dac_link_pkg;
    // Phases of the device's serial receiver.
    typedef enum logic [2:0] {
        dev_idle = 3'b000,
        dev_addr = 3'b001,
        dev_cmd = 3'b010,
        dev_wdata = 3'b011,
        dev_rdata = 3'b100,
        dev_ack = 3'b101,
        dev_mack = 3'b110
    } dev_state_t;
    // Steps of the host's bit sequencer.
    typedef enum logic [2:0] {
        hst_idle = 3'b000,
        hst_start = 3'b001,
        hst_bit = 3'b010,
        hst_stop = 3'b011,
        hst_rstart = 3'b100
    } hst_state_t;
endpackage

// ### smbus_dac_slave_port_tb.sv
// Testbench for both ends of the two-wire DAC link.
// Assumes a 125 MHz aclk; a second device's bus is driven bit by bit.
`timescale 1ns/10ps
`include "dac_link_defines.svh"
module smbus_dac_slave_port_tb
    import dac_link_pkg::*;
;
    localparam int HC = 8; // Short quarter, brief run.
    logic aclk = 1'b0, aresetn = 1'b0, bad2 = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, converting;
    logic [1:0] bresp, rresp;
    logic [7:0] dac_code, setup_register, dac_code2;
    logic [32:0] exp_q[$], e; // Expected reads: compare flag and value.
    int num_errors = 0, total_checks = 0;
    dac_link_if link(), link2();
    // Clock at 8 ns.
    always #4 aclk = ~aclk;
    dac_link_host #(.HALF_CYC(HC)) dac_link_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.host));
    dac_link_device dac_link_device_i (.aclk(aclk), .aresetn(aresetn), .link(link.device),
        .dac_code(dac_code), .setup_register(setup_register), .converting(converting));
    dac_link_device dac_link_device_i2 (.aclk(aclk), .aresetn(aresetn), .link(link2.device),
        .dac_code(dac_code2), .setup_register(), .converting());
    dac_link_monitor #(.HALF_CYC(HC)) dac_link_monitor_i (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
        .sda(link.sda), .scl_oe_host(link.scl_oe_host), .sda_oe_host(link.sda_oe_host), .sda_oe_dev(link.sda_oe_dev));
    // Compare and count.
    task check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    // Verdict and end of run.
    task close_out;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One AXI write; address and data held until taken.
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    // One AXI read; data taken where rvalid is seen.
    task axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
    endtask
    // One byte write or read, waiting for the link.
    task xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] d);
        logic [31:0] r;
        if (!rd) axi_wr(`HOST_REG_WDATA, {24'h0, d});
        axi_wr(`HOST_REG_CTRL, {23'h0, rd, cmd});
        do begin
            exp_q.push_back(33'h0);
            axi_rd(`HOST_REG_STATUS, r);
        end while (r[16] !== 1'b0);
        check({bresp, rresp, r[17:16]}, 6'h00);
        if (rd) begin
            exp_q.push_back({1'b1, 24'h0, d});
            axi_rd(`HOST_REG_STATUS, r);
        end
    endtask
    // Half a bit on the second bus: clock, then data.
    task ln(input logic c, input logic d);
        @(posedge aclk);
        link2.scl_oe_host <= ~c;
        repeat (4) @(posedge aclk);
        link2.sda_oe_host <= ~d;
        repeat (3) @(posedge aclk);
    endtask
    // One byte on the second bus, then a released ack slot.
    task put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ln(1'b0, b[i]);
            ln(1'b1, b[i]);
        end
        ln(1'b0, 1'b1);
        ln(1'b1, 1'b1);
        check(link2.sda, 1'b1);
    endtask
    // Read results meet the oldest note.
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = exp_q.pop_front();
            if (e[32]) check(rdata & 32'h0003_00ff, e[31:0]);
        end
    end
    // Remember any drive by the second device.
    always @(posedge aclk) if (link2.sda_oe_dev === 1'b1) bad2 <= 1'b1;
    // Main sequence.
    initial begin
        logic [7:0] v;
        logic [31:0] r;
        link2.scl_oe_host = 1'b0;
        link2.sda_oe_host = 1'b0;
        void'($urandom(34));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check(dac_code, 8'h00);
        check(setup_register, 8'h00);
        check(converting, 1'b1);
        v = 8'($urandom);
        xfer(1'b0, `CMD_DAC_CODE, v);
        check(dac_code, v);
        xfer(1'b1, `CMD_DAC_CODE, v);
        xfer(1'b0, `CMD_SETUP, 8'hff);
        check(setup_register, 8'h01);
        check(converting, 1'b0);
        v = 8'($urandom);
        xfer(1'b0, `CMD_DAC_CODE, v);
        check(dac_code, v);
        xfer(1'b1, `CMD_SETUP, 8'h01);
        xfer(1'b0, `CMD_SETUP, 8'h00);
        check(converting, 1'b1);
        xfer(1'b0, 8'h05, 8'ha5);
        check(dac_code, v);
        check(setup_register, 8'h00);
        xfer(1'b1, 8'h05, 8'h00);
        exp_q.push_back({1'b1, 24'h0, 8'h05});
        axi_rd(4'hc, r);
        check(link.scl, 1'b1);
        check(link.sda, 1'b1);
        ln(1'b1, 1'b1);
        ln(1'b1, 1'b0);
        put(8'h92);
        put(8'h00);
        put(8'h5a);
        ln(1'b0, 1'b0);
        ln(1'b1, 1'b0);
        ln(1'b1, 1'b1);
        check(dac_code2, 8'h00);
        check(bad2, 1'b0);
        close_out();
    end
    // Watchdog against a hang.
    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        close_out();
    end
endmodule // smbus_dac_slave_port_tb
